/* File: design/i2cd_target.sv */
/*
  i2cd_target.sv: i2c target of a 16-bit dac: address match, command/data reception,
  update at the acknowledge after the lower byte, read-back of upper, lower and command bytes.
  assumes: scl/sda/addr_select_pin are asynchronous pins; sda is open drain (sda_oe pulls low).
*/
`timescale 1ns/1ps
`include "i2cd_cfg.svh"
module i2cd_target import i2cd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // strap
  input wire logic addr_select_pin,
  // analog-side state
  output logic [15:0] dac_code,
  output logic [15:0] temp_code,
  output i2cd_pwr_e power_setting_select,
  output logic [7:0] last_cmd,
  output logic update_pulse
);
  i2cd_line_if ev ();
  i2cd_line_front u_front (.clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .ev(ev));

  logic sel_s;
  i2cd_sync u_sel (.clk(clk), .reset_n(reset_n), .d(addr_select_pin), .q(sel_s));

  i2cd_state_e st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] bidx_q, bidx_d;      // write: 0 command, 1 upper, 2 lower; read: 0 upper, 1 lower, 2 command
  logic bcast_q, bcast_d;
  logic rw_q, rw_d;
  logic ack_q, ack_d;              // acknowledge this byte
  logic hold_q, hold_d;            // drive low during current slot
  logic [7:0] up_q, up_d;
  logic [7:0] lo_q, lo_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] dac_q, dac_d;
  logic [15:0] tmp_q, tmp_d;
  logic [15:0] rb_q, rb_d;         // read-back data word
  logic [2:0] tpwr_q, tpwr_d;      // power setting held with temporary word
  logic tpd_q, tpd_d;              // temporary word carries a power setting
  i2cd_pwr_e pwr_q, pwr_d;
  logic upd_q, upd_d;
  logic pair_done_q, pair_done_d;

  logic addr_hit;
  logic addr_bc;
  logic cmd_ok;
  logic load_tmp;
  logic load_dac;
  logic from_tmp;
  logic [7:0] tx_byte;

  function automatic i2cd_pwr_e pwr_decode(input logic [2:0] m);
    unique case (m[2:1])
      2'b00: pwr_decode = m[0] ? I2CD_PWR_FAST_E : I2CD_PWR_LOW_E;
      2'b01: pwr_decode = I2CD_PWR_PD1K_E;
      2'b10: pwr_decode = I2CD_PWR_PD100K_E;
      2'b11: pwr_decode = I2CD_PWR_HIZ_E;
    endcase
  endfunction : pwr_decode

  always_comb begin
    addr_bc = (sh_q[6:0] == `I2CD_ADDR_BCAST) && !ev.sda_level;
    addr_hit = (sh_q[6:2] == `I2CD_ADDR_PRESET) && (sh_q[1] == sel_s) && !sh_q[0];
    cmd_ok = bcast_q ? (cmd_q[`I2CD_CMD_LD_HI_BIT] && cmd_q[`I2CD_CMD_LD_LO_BIT])
                     : (cmd_q[7:6] == 2'b00);
    load_tmp = !cmd_q[`I2CD_CMD_LD_HI_BIT] ||
               (cmd_q[`I2CD_CMD_LD_HI_BIT] && cmd_q[`I2CD_CMD_LD_LO_BIT] && cmd_q[`I2CD_CMD_SRC_BIT]);
    load_dac = cmd_q[`I2CD_CMD_LD_HI_BIT] || cmd_q[`I2CD_CMD_LD_LO_BIT];
    from_tmp = cmd_q[`I2CD_CMD_LD_HI_BIT] && !(cmd_q[`I2CD_CMD_LD_LO_BIT] && cmd_q[`I2CD_CMD_SRC_BIT]);
    unique case (bidx_q)
      2'd0: tx_byte = rb_q[15:8];
      2'd1: tx_byte = rb_q[7:0];
      default: tx_byte = cmd_q;
    endcase
  end

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    bidx_d = bidx_q;
    bcast_d = bcast_q;
    rw_d = rw_q;
    ack_d = ack_q;
    hold_d = hold_q;
    up_d = up_q;
    lo_d = lo_q;
    cmd_d = cmd_q;
    dac_d = dac_q;
    tmp_d = tmp_q;
    rb_d = rb_q;
    tpwr_d = tpwr_q;
    tpd_d = tpd_q;
    pwr_d = pwr_q;
    upd_d = 1'b0;
    pair_done_d = pair_done_q;
    if (ev.start_evt) begin
      // a partial pair is simply dropped
      st_d = I2CD_ADDR;
      bit_d = 4'd0;
      hold_d = 1'b0;
    end else if (ev.stop_evt) begin
      st_d = I2CD_IDLE;
      hold_d = 1'b0;
    end else begin
      unique case (st_q)
        I2CD_IDLE: hold_d = 1'b0;
        I2CD_ADDR: begin
          if (ev.scl_rise) begin
            sh_d = {sh_q[6:0], ev.sda_level};
            bit_d = bit_q + 4'd1;
            if (bit_q == 4'd7) begin
              rw_d = ev.sda_level;
              bcast_d = addr_bc;
              ack_d = addr_bc || addr_hit;
            end
          end else if (ev.scl_fall && bit_q == 4'd8) begin
            hold_d = ack_q;
            st_d = ack_q ? I2CD_ADDR_ACK : I2CD_IDLE;
          end
        end
        I2CD_ADDR_ACK: begin
          if (ev.scl_fall) begin
            bit_d = 4'd0;
            bidx_d = 2'd0;
            if (rw_q) begin
              st_d = I2CD_RD_BYTE;
              hold_d = !rb_q[15];
              bit_d = 4'd1;
            end else begin
              st_d = I2CD_WR_BYTE;
              hold_d = 1'b0;
            end
          end
        end
        I2CD_WR_BYTE: begin
          if (ev.scl_rise) begin
            sh_d = {sh_q[6:0], ev.sda_level};
            bit_d = bit_q + 4'd1;
          end else if (ev.scl_fall && bit_q == 4'd8) begin
            hold_d = 1'b1; // every byte acknowledged
            st_d = I2CD_WR_ACK;
            unique case (bidx_q)
              2'd0: cmd_d = sh_q;
              2'd1: up_d = sh_q;
              default: lo_d = sh_q;
            endcase
            pair_done_d = (bidx_q == 2'd2);
          end
        end
        I2CD_WR_ACK: begin
          if (ev.scl_fall) begin
            hold_d = 1'b0;
            bit_d = 4'd0;
            st_d = I2CD_WR_BYTE;
            bidx_d = (bidx_q == 2'd2) ? 2'd1 : bidx_q + 2'd1;
            if (pair_done_q && cmd_ok) begin
              pair_done_d = 1'b0;
              upd_d = 1'b1;
              rb_d = from_tmp ? {up_q, lo_q} : {up_q, lo_q};
              if (load_tmp) begin
                tmp_d = {up_q, lo_q};
                tpd_d = cmd_q[`I2CD_CMD_PD_BIT];
                tpwr_d = up_q[7:5];
              end
              if (load_dac) begin
                if (from_tmp) begin
                  if (tpd_q) pwr_d = pwr_decode(tpwr_q);
                  else begin
                    dac_d = tmp_q;
                    if (pwr_q != I2CD_PWR_FAST_E) pwr_d = I2CD_PWR_LOW_E;
                  end
                end else if (cmd_q[`I2CD_CMD_PD_BIT]) begin
                  pwr_d = pwr_decode(up_q[7:5]);
                end else begin
                  dac_d = {up_q, lo_q};
                  if (pwr_q != I2CD_PWR_FAST_E) pwr_d = I2CD_PWR_LOW_E;
                end
              end
            end else begin
              pair_done_d = 1'b0;
            end
          end
        end
        I2CD_RD_BYTE: begin
          if (ev.scl_fall) begin
            if (bit_q == 4'd8) begin
              hold_d = 1'b0;
              st_d = I2CD_RD_ACK;
            end else begin
              hold_d = !tx_byte[3'(7 - bit_q)];
              bit_d = bit_q + 4'd1;
            end
          end
        end
        I2CD_RD_ACK: begin
          if (ev.scl_rise) begin
            ack_d = !ev.sda_level;
          end else if (ev.scl_fall) begin
            if (ack_q) begin
              bidx_d = (bidx_q == 2'd2) ? 2'd0 : bidx_q + 2'd1;
              st_d = I2CD_RD_BYTE;
              bit_d = 4'd1;
              unique case (bidx_q)
                2'd0: hold_d = !rb_q[7];
                2'd1: hold_d = !cmd_q[7];
                default: hold_d = !rb_q[15];
              endcase
            end else begin
              st_d = I2CD_IDLE;
              hold_d = 1'b0;
            end
          end
        end
        default: st_d = I2CD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= I2CD_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      bidx_q <= 2'h0;
      bcast_q <= 1'b0;
      rw_q <= 1'b0;
      ack_q <= 1'b0;
      hold_q <= 1'b0;
      up_q <= 8'h00;
      lo_q <= 8'h00;
      cmd_q <= `I2CD_CMD_RESET;
      dac_q <= `I2CD_DAC_RESET;
      tmp_q <= `I2CD_DAC_RESET;
      rb_q <= `I2CD_DAC_RESET;
      tpwr_q <= `I2CD_PWR_LOW;
      tpd_q <= 1'b0;
      pwr_q <= I2CD_PWR_LOW_E;
      upd_q <= 1'b0;
      pair_done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      bidx_q <= bidx_d;
      bcast_q <= bcast_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      hold_q <= hold_d;
      up_q <= up_d;
      lo_q <= lo_d;
      cmd_q <= cmd_d;
      dac_q <= dac_d;
      tmp_q <= tmp_d;
      rb_q <= rb_d;
      tpwr_q <= tpwr_d;
      tpd_q <= tpd_d;
      pwr_q <= pwr_d;
      upd_q <= upd_d;
      pair_done_q <= pair_done_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = hold_q;
  assign dac_code = dac_q;
  assign temp_code = tmp_q;
  assign power_setting_select = pwr_q;
  assign last_cmd = cmd_q;
  assign update_pulse = upd_q;

  a_sda_change_low: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(sda_oe) |-> !u_front.scl_q)
    else $error("data line moved at a clock rise");
  a_update_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
    update_pulse |-> $past(ev.scl_fall) && $past(st_q) == I2CD_WR_ACK)
    else $error("update away from acknowledge fall");
  a_dac_only_on_update: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(dac_code) |-> update_pulse)
    else $error("dac register changed without update");
  a_nack_release: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == I2CD_RD_ACK && ev.scl_fall && !ack_q && !ev.start_evt && !ev.stop_evt) |=> !sda_oe && st_q == I2CD_IDLE)
    else $error("bus not released after not-acknowledge");
  a_stop_release: assert property (@(posedge clk) disable iff (!reset_n)
    ev.stop_evt |=> !sda_oe ##1 !sda_oe)
    else $error("line held after stop");
  a_wr_ack_drive: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == I2CD_WR_ACK && !ev.scl_fall && !ev.start_evt && !ev.stop_evt) |-> sda_oe)
    else $error("write byte not acknowledged");
  a_bcast_no_read: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q == I2CD_ADDR && ev.scl_rise && bit_q == 4'd7 && sh_q[6:0] == `I2CD_ADDR_BCAST && ev.sda_level
     && !addr_hit) |=> !ack_q)
    else $error("broadcast read acknowledged");
  a_pd_exit: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(dac_code)) |-> (power_setting_select == I2CD_PWR_LOW_E || power_setting_select == I2CD_PWR_FAST_E))
    else $error("dac update left device powered down");
endmodule : i2cd_target

/* File: pkg/i2cd_cfg.svh */
/*
  i2cd_cfg.svh: constants for the i2c dac target (addresses, command bits, power codes, reset values).
  assumes: included by bare name from the target design file.
*/
`ifndef I2CD_CFG_SVH
`define I2CD_CFG_SVH
`define I2CD_ADDR_PRESET 5'h13
`define I2CD_ADDR_BCAST 7'h48
`define I2CD_CMD_PD_BIT 0
`define I2CD_CMD_SRC_BIT 2
`define I2CD_CMD_LD_LO_BIT 4
`define I2CD_CMD_LD_HI_BIT 5
`define I2CD_PWR_LOW 3'h0
`define I2CD_PWR_FAST 3'h1
`define I2CD_PWR_PD1K 3'h2
`define I2CD_PWR_PD100K 3'h3
`define I2CD_PWR_HIZ 3'h4
`define I2CD_DAC_RESET 16'h0000
`define I2CD_CMD_RESET 8'h00
`endif

/* File: pkg/i2cd_pkg.sv */
/*
  i2cd_pkg.sv: types shared by the i2c dac target modules.
  assumes: i2cd_cfg.svh holds the numeric constants.
*/
package i2cd_pkg;
  typedef enum logic [2:0] {
    I2CD_PWR_LOW_E,
    I2CD_PWR_FAST_E,
    I2CD_PWR_PD1K_E,
    I2CD_PWR_PD100K_E,
    I2CD_PWR_HIZ_E
  } i2cd_pwr_e;
  typedef enum logic [2:0] {
    I2CD_IDLE,
    I2CD_ADDR,
    I2CD_ADDR_ACK,
    I2CD_WR_BYTE,
    I2CD_WR_ACK,
    I2CD_RD_BYTE,
    I2CD_RD_ACK
  } i2cd_state_e;
endpackage : i2cd_pkg

/* File: pkg/i2cd_line_if.sv */
/*
  i2cd_line_if.sv: synchronised bus-line events passed from the line front end to the protocol engine.
  assumes: single clock domain clk.
*/
`timescale 1ns/1ps
interface i2cd_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_level;
  logic start_evt;
  logic stop_evt;
  modport front (output scl_rise, output scl_fall, output sda_level, output start_evt, output stop_evt);
  modport engine (input scl_rise, input scl_fall, input sda_level, input start_evt, input stop_evt);
endinterface : i2cd_line_if

/* File: design/i2cd_sync.sv */
/*
  i2cd_sync.sv: two-flop synchroniser for one asynchronous level.
  assumes: d comes from outside the clk domain.
*/
`timescale 1ns/1ps
module i2cd_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level
  input wire logic d,
  output logic q
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule : i2cd_sync

/* File: design/i2cd_line_front.sv */
/*
  i2cd_line_front.sv: synchronises scl and sda, finds clock edges and start/stop conditions.
  assumes: bus pins idle high; clk far faster than scl.
*/
`timescale 1ns/1ps
module i2cd_line_front (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  i2cd_line_if.front ev
);
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic scl_d;
  logic sda_d;
  i2cd_sync u_scl (.clk(clk), .reset_n(reset_n), .d(scl_in), .q(scl_s));
  i2cd_sync u_sda (.clk(clk), .reset_n(reset_n), .d(sda_in), .q(sda_s));
  always_comb begin
    scl_d = scl_s;
    sda_d = sda_s;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end
  assign ev.scl_rise = scl_s && !scl_q;
  assign ev.scl_fall = !scl_s && scl_q;
  assign ev.sda_level = sda_s;
  // sda moving while scl stays high marks start or stop
  assign ev.start_evt = scl_s && scl_q && sda_q && !sda_s;
  assign ev.stop_evt = scl_s && scl_q && !sda_q && sda_s;
endmodule : i2cd_line_front

/* File: sim/i2cd_master.sv */
/*
  i2cd_master.sv: behavioural bus controller driving scl and the open-drain data line.
  assumes: sda has a pull-up; dev_oe high pulls it low; callers enter tasks on a clk falling edge.
*/
`timescale 1ns/1ps
module i2cd_master (
  // device pull on the data line
  input wire logic dev_oe,
  // bus lines
  output logic scl,
  output logic sda
);
  logic m_oe = 1'b0;
  initial scl = 1'b1;
  // wired-and with pull-up: released line reads high
  assign sda = ~(m_oe | dev_oe);
  // one 80 ns bit: data moves while scl low, sampled in the high phase
  task automatic bit_io(input logic b, output logic s);
    m_oe = ~b;
    #20 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
    #20;
  endtask : bit_io
  // also serves as repeated start from scl low
  task automatic start();
    m_oe = 1'b0;
    #20 scl = 1'b1;
    #40 m_oe = 1'b1;
    #40 scl = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    m_oe = 1'b1;
    #20 scl = 1'b1;
    #40 m_oe = 1'b0;
    #40;
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wr_byte
  // mack low ends the read with a not-acknowledge
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask : rd_byte
endmodule : i2cd_master

/* File: sim/test_i2c_dac_data_readback_port.sv */
/*
  test_i2c_dac_data_readback_port.sv: self-checking bench for the dac bus target.
  assumes: i2cd_master plays the controller; expected updates are queued before each write.
*/
`timescale 1ns/1ps
module test_i2c_dac_data_readback_port import i2cd_pkg::*; ();
  typedef struct packed {logic [15:0] d; i2cd_pwr_e p;} i2cd_tb_exp_s;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sel = 1'b0;
  logic scl, sda, sda_oe, update_pulse, ack;
  logic [15:0] dac_code, temp_code, dac_now, w, v;
  logic [7:0] last_cmd, a_w, b;
  i2cd_pwr_e power_setting_select, pwr_now;
  i2cd_tb_exp_s q[$];
  i2cd_tb_exp_s e;
  int num_errors = 0;
  int check_count = 0;
  initial forever #2.5 clk = ~clk;
  i2cd_master m (.dev_oe(sda_oe), .scl(scl), .sda(sda));
  i2cd_target dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .addr_select_pin(sel), .dac_code(dac_code), .temp_code(temp_code),
    .power_setting_select(power_setting_select), .last_cmd(last_cmd), .update_pulse(update_pulse));
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask : chk
  function automatic i2cd_pwr_e pw(input logic [2:0] c);
    casez (c)
      3'b000: return I2CD_PWR_LOW_E;
      3'b001: return I2CD_PWR_FAST_E;
      3'b01?: return I2CD_PWR_PD1K_E;
      3'b10?: return I2CD_PWR_PD100K_E;
      default: return I2CD_PWR_HIZ_E;
    endcase
  endfunction : pw
  // data update: fast kept, power-down left for low power
  task automatic note_data(input logic [15:0] d);
    pwr_now = (pwr_now == I2CD_PWR_FAST_E) ? I2CD_PWR_FAST_E : I2CD_PWR_LOW_E;
    dac_now = d;
    q.push_back('{d, pwr_now});
  endtask : note_data
  task automatic note_pwr(input i2cd_pwr_e p);
    pwr_now = p;
    q.push_back('{dac_now, p});
  endtask : note_pwr
  // n words w, w+1, ... under one command, then stop and wait for queued updates
  task automatic wseq(input logic [7:0] a, input logic [7:0] c, input logic [15:0] w0, input int n,
                      input logic ea);
    logic [15:0] x;
    @(negedge clk);
    m.start();
    m.wr_byte(a, ack);
    chk("address ack", ack, ea);
    if (ea) begin
      m.wr_byte(c, ack);
      chk("command ack", ack, 1'b1);
      for (int i = 0; i < n; i++) begin
        x = w0 + 16'(i);
        m.wr_byte(x[15:8], ack);
        chk("upper ack", ack, 1'b1);
        m.wr_byte(x[7:0], ack);
        chk("lower ack", ack, 1'b1);
      end
    end
    m.stop();
    for (int k = 0; k < 400 && q.size() > 0; k++) @(negedge clk);
    chk("updates pending", 16'(q.size()), 16'h0000);
    if (q.size() != 0) results();
  endtask : wseq
  task automatic rseq(input logic [15:0] d, input logic [7:0] c);
    @(negedge clk);
    m.start();
    m.wr_byte(a_w | 8'h01, ack);
    chk("read address ack", ack, 1'b1);
    m.rd_byte(1'b1, b);
    chk("read upper", b, d[15:8]);
    m.rd_byte(1'b1, b);
    chk("read lower", b, d[7:0]);
    m.rd_byte(1'b0, b);
    chk("read command", b, c);
    m.stop();
    chk("line released", sda_oe, 1'b0);
  endtask : rseq
  always @(negedge clk) begin
    if (update_pulse === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk("dac code", dac_code, e.d);
      chk("power setting", power_setting_select, e.p);
      chk("scl low at update", scl, 1'b0);
    end
  end
  always @(sda_oe) if (reset_n === 1'b1) chk("scl low at data change", scl, 1'b0);
  initial begin
    void'($urandom(32'h3df35d0a));
    sel = 1'($urandom);
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("dac at power-up", dac_code, 16'h0000);
    chk("power at power-up", power_setting_select, I2CD_PWR_LOW_E);
    dac_now = 16'h0000;
    pwr_now = I2CD_PWR_LOW_E;
    a_w = {5'b10011, sel, 2'b00};
    note_data(16'h4000);
    wseq(a_w, 8'h10, 16'h4000, 1, 1'b1);
    rseq(16'h4000, 8'h10);
    for (int i = 0; i < 8; i++) begin
      note_pwr(pw(3'(i)));
      wseq(a_w, 8'h11, {3'(i), 13'h0000}, 1, 1'b1);
    end
    w = 16'($urandom);
    wseq(a_w, 8'h00, w, 1, 1'b1);
    chk("temp store", temp_code, w);
    chk("dac kept on store", dac_code, dac_now);
    v = 16'($urandom);
    note_data(w);
    wseq(a_w, 8'h20, v, 1, 1'b1);
    rseq(v, 8'h20);
    sel = ~sel;
    note_pwr(I2CD_PWR_HIZ_E);
    wseq(8'h90, 8'h35, 16'hc000, 1, 1'b1);
    w = 16'($urandom);
    note_pwr(I2CD_PWR_HIZ_E);
    wseq(8'h90, 8'h30, 16'($urandom), 1, 1'b1);
    wseq(8'h91, 8'h00, 16'h0000, 0, 1'b0);
    sel = ~sel;
    wseq(a_w, 8'h00, w, 1, 1'b1);
    sel = ~sel;
    note_data(w);
    wseq(8'h90, 8'h30, 16'($urandom), 1, 1'b1);
    sel = ~sel;
    wseq({5'b10011, ~sel, 2'b00}, 8'h10, 16'h1234, 1, 1'b0);
    @(negedge clk);
    m.start();
    m.wr_byte(8'h08, ack);
    chk("master code ack", ack, 1'b0);
    wseq(a_w, 8'h50, 16'($urandom), 1, 1'b1);
    chk("dac kept on bad command", dac_code, dac_now);
    note_pwr(I2CD_PWR_FAST_E);
    wseq(a_w, 8'h11, 16'h2000, 1, 1'b1);
    w = 16'($urandom);
    for (int i = 0; i < 4; i++) note_data(w + 16'(i));
    wseq(a_w, 8'h10, w, 4, 1'b1);
    @(negedge clk);
    m.start();
    m.wr_byte(a_w, ack);
    m.wr_byte(8'h10, ack);
    m.wr_byte(8'h5a, ack);
    m.stop();
    repeat (20) @(negedge clk);
    chk("dac after partial pair", dac_code, dac_now);
    chk("temp after partial pair", temp_code, dac_now);
    results();
  end
endmodule : test_i2c_dac_data_readback_port
